// >>> slirq_pkg.sv
// Purpose: Constants for the serial link interrupt enable block.
// Assumes: Byte-wide register port, registers at printed offsets.
// Notes:   Offsets and bit positions live here only.
package slirq_pkg;
   localparam logic [11:0] ADDR_ENABLE_A = 12'h4B8;
   localparam logic [11:0] ADDR_ENABLE_B = 12'h4B9;
   localparam logic [11:0] ADDR_STATUS_A = 12'h4BA;
   localparam logic [11:0] ADDR_STATUS_B = 12'h4BB;
   localparam logic [7:0]  ENABLE_A_RESET = 8'h00;
   localparam logic [7:0]  ENABLE_B_RESET = 8'h00;
   localparam logic [7:0]  ENABLE_B_MASK  = 8'h01;
   localparam logic [7:0]  STATUS_RESET   = 8'h00;
   localparam int BIT_BAD_DISPARITY = 7;
   localparam int BIT_BAD_CODE      = 6;
   localparam int BIT_UNEXP_CTRL    = 5;
   localparam int BIT_DESKEW        = 4;
   localparam int BIT_INIT_SYNC     = 3;
   localparam int BIT_CHECKSUM      = 2;
   localparam int BIT_FRAME_ALIGN   = 1;
   localparam int BIT_CODEGROUP     = 0;
   localparam int BIT_MISMATCH      = 0;
   localparam int ILAS_OCTETS       = 14;
endpackage

// >>> slirq_top.sv
// Purpose: Interrupt enables and flags for the serial receive link.
// Assumes: Inputs other than resetn_in synchronous to clk_in; events are one-cycle pulses.
// Notes:   Status flags are sticky; a write of one clears a flag.
`timescale 1ns/100ps
module slirq_top #(
   parameter int OCTETS = slirq_pkg::ILAS_OCTETS
) (
   input  wire logic                clk_in,
   input  wire logic                resetn_in,
   input  wire logic [11:0]         reg_addr_in,
   input  wire logic                reg_write_in,
   input  wire logic [7:0]          reg_wdata_in,
   output logic      [7:0]          reg_rdata_out,
   input  wire logic [7:0]          link_event_in,
   input  wire logic                ilas_done_in,
   input  wire logic [OCTETS*8-1:0] ilas_rx_in,
   input  wire logic [OCTETS*8-1:0] ilas_cfg_in,
   input  wire logic [7:0]          ilas_sent_cks_in,
   output logic                     irq_out
);
   // ****************************************************************
   // Parameter check
   // ****************************************************************
   // The checksum needs at least one data octet ahead of its own octet.
   if (OCTETS < 2) begin : g_octets_check
      $error("OCTETS must be at least 2");
   end
   logic [1:0] rst_sync_reg;
   logic       rstn;
   logic       armed;
   logic [7:0] enable_a_reg, enable_b_reg, status_a_reg, status_b_reg;
   logic [7:0] computed_cks, event_a, event_b;
   logic       cks_good, mismatch;
   // ****************************************************************
   // Reset release
   // ****************************************************************
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) rst_sync_reg <= 2'h0;
      else rst_sync_reg <= {rst_sync_reg[0], 1'h1};
   end
   assign rstn = rst_sync_reg[1];
   // ****************************************************************
   // ILAS checks
   // ****************************************************************
   // Checksum is the low byte of the octet sum over all but the last.
   function automatic logic [7:0] ilas_sum(input logic [OCTETS*8-1:0] d);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < OCTETS - 1; i++) s = s + d[i*8 +: 8];
      return s;
   endfunction
   assign computed_cks = ilas_sum(ilas_rx_in);
   assign cks_good = (computed_cks == ilas_sent_cks_in);
   assign mismatch = (ilas_rx_in != ilas_cfg_in);
   always_comb begin
      event_a = link_event_in;
      event_a[slirq_pkg::BIT_CHECKSUM] = ilas_done_in && cks_good;
      event_b = 8'h00;
      event_b[slirq_pkg::BIT_MISMATCH] = ilas_done_in && mismatch;
   end
   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         enable_a_reg <= slirq_pkg::ENABLE_A_RESET;
         enable_b_reg <= slirq_pkg::ENABLE_B_RESET;
      end else if (reg_write_in) begin
         if (reg_addr_in == slirq_pkg::ADDR_ENABLE_A)
            enable_a_reg <= reg_wdata_in;
         if (reg_addr_in == slirq_pkg::ADDR_ENABLE_B)
            enable_b_reg <= reg_wdata_in & slirq_pkg::ENABLE_B_MASK;
      end
   end
   // Set wins over a simultaneous write-one clear so no event is lost.
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         status_a_reg <= slirq_pkg::STATUS_RESET;
         status_b_reg <= slirq_pkg::STATUS_RESET;
      end else begin
         status_a_reg <= (status_a_reg & ~((reg_write_in &&
            reg_addr_in == slirq_pkg::ADDR_STATUS_A) ? reg_wdata_in
            : 8'h00)) | event_a;
         status_b_reg <= (status_b_reg & ~((reg_write_in &&
            reg_addr_in == slirq_pkg::ADDR_STATUS_B) ? reg_wdata_in
            : 8'h00)) | (event_b & slirq_pkg::ENABLE_B_MASK);
      end
   end
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) reg_rdata_out <= 8'h00;
      else begin
         case (reg_addr_in)
            slirq_pkg::ADDR_ENABLE_A: reg_rdata_out <= enable_a_reg;
            slirq_pkg::ADDR_ENABLE_B: reg_rdata_out <= enable_b_reg;
            slirq_pkg::ADDR_STATUS_A: reg_rdata_out <= status_a_reg;
            slirq_pkg::ADDR_STATUS_B: reg_rdata_out <= status_b_reg;
            default:                  reg_rdata_out <= 8'h00;
         endcase
      end
   end
   // A flag only counts while its own enable bit is one.
   assign armed = |(status_a_reg & enable_a_reg) ||
                  |(status_b_reg & enable_b_reg);
   // Registered so the pin never glitches while flags and enables move.
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) irq_out <= 1'h0;
      else irq_out <= armed;
   end
   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_flag_armed;
      |(status_a_reg & enable_a_reg) || |(status_b_reg & enable_b_reg);
   endsequence
   property p_irq_follows;
      @(posedge clk_in) disable iff (!rstn)
      s_flag_armed |=> irq_out;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("irq not raised for armed flag");
   property p_irq_cause;
      @(posedge clk_in) disable iff (!rstn)
      irq_out |-> $past(armed);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("irq without armed flag");
   property p_bdis_gate;
      @(posedge clk_in) disable iff (!rstn)
      (status_a_reg[slirq_pkg::BIT_BAD_DISPARITY] &&
       !enable_a_reg[slirq_pkg::BIT_BAD_DISPARITY] &&
       (status_a_reg & enable_a_reg) == 8'h00 &&
       (status_b_reg & enable_b_reg) == 8'h00) |=> !irq_out;
   endproperty
   a_bdis_gate: assert property (p_bdis_gate)
      else $error("disabled flag raised irq");
   property p_resv_zero;
      @(posedge clk_in) disable iff (!rstn)
      enable_b_reg[7:1] == 7'h00;
   endproperty
   a_resv_zero: assert property (p_resv_zero)
      else $error("reserved enable bits set");
   property p_cks_set;
      @(posedge clk_in) disable iff (!rstn)
      (ilas_done_in && cks_good) |=> status_a_reg[slirq_pkg::BIT_CHECKSUM];
   endproperty
   a_cks_set: assert property (p_cks_set)
      else $error("checksum flag not set");
   property p_mis_set;
      @(posedge clk_in) disable iff (!rstn)
      (ilas_done_in && ilas_rx_in != ilas_cfg_in) |=>
         status_b_reg[slirq_pkg::BIT_MISMATCH];
   endproperty
   a_mis_set: assert property (p_mis_set)
      else $error("mismatch flag not set");
   property p_ev_set;
      @(posedge clk_in) disable iff (!rstn)
      link_event_in[slirq_pkg::BIT_UNEXP_CTRL] |=>
         status_a_reg[slirq_pkg::BIT_UNEXP_CTRL];
   endproperty
   a_ev_set: assert property (p_ev_set)
      else $error("event flag lost");
   property p_en_write;
      @(posedge clk_in) disable iff (!rstn)
      (reg_write_in && reg_addr_in == slirq_pkg::ADDR_ENABLE_A) |=>
         enable_a_reg == $past(reg_wdata_in);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable A write not stored");
   // A write-one-to-clear of status A that meets no event on that bit.
   sequence s_clear_a_quiet;
      reg_write_in && reg_addr_in == slirq_pkg::ADDR_STATUS_A &&
      reg_wdata_in[slirq_pkg::BIT_BAD_CODE] &&
      !link_event_in[slirq_pkg::BIT_BAD_CODE];
   endsequence
   property p_clear_a;
      @(posedge clk_in) disable iff (!rstn)
      s_clear_a_quiet |=> !status_a_reg[slirq_pkg::BIT_BAD_CODE];
   endproperty
   a_clear_a: assert property (p_clear_a)
      else $error("status flag not cleared");
   sequence s_set_meets_clear;
      reg_write_in && reg_addr_in == slirq_pkg::ADDR_STATUS_A &&
      reg_wdata_in[slirq_pkg::BIT_BAD_DISPARITY] &&
      link_event_in[slirq_pkg::BIT_BAD_DISPARITY];
   endsequence
   property p_set_wins;
      @(posedge clk_in) disable iff (!rstn)
      s_set_meets_clear |=> status_a_reg[slirq_pkg::BIT_BAD_DISPARITY];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost to a clear");
   property p_cks_bad;
      @(posedge clk_in) disable iff (!rstn)
      (ilas_done_in && computed_cks != ilas_sent_cks_in &&
       !status_a_reg[slirq_pkg::BIT_CHECKSUM]) |=>
         !status_a_reg[slirq_pkg::BIT_CHECKSUM];
   endproperty
   a_cks_bad: assert property (p_cks_bad)
      else $error("bad checksum set the flag");
   property p_mis_quiet;
      @(posedge clk_in) disable iff (!rstn)
      (ilas_done_in && ilas_rx_in == ilas_cfg_in &&
       !status_b_reg[slirq_pkg::BIT_MISMATCH]) |=>
         !status_b_reg[slirq_pkg::BIT_MISMATCH];
   endproperty
   a_mis_quiet: assert property (p_mis_quiet)
      else $error("mismatch flag without a mismatch");
   property p_b_gate;
      @(posedge clk_in) disable iff (!rstn)
      (status_b_reg[slirq_pkg::BIT_MISMATCH] &&
       !enable_b_reg[slirq_pkg::BIT_MISMATCH] &&
       (status_a_reg & enable_a_reg) == 8'h00) |=> !irq_out;
   endproperty
   a_b_gate: assert property (p_b_gate)
      else $error("disabled mismatch flag raised irq");
   property p_reset_vals;
      @(posedge clk_in)
      $rose(rstn) |-> enable_a_reg == slirq_pkg::ENABLE_A_RESET &&
         enable_b_reg == slirq_pkg::ENABLE_B_RESET && !irq_out;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("registers not at reset values");
endmodule // slirq_top

// >>> slirq_tx_model.sv
// Purpose: Link transmitter model that sends a fixed ILAS frame.
// Assumes: Checksum is the low byte of the sum of octets 0 to 12.
// Notes:   A wrong checksum is sent only when the bench asks for one.
`timescale 1ns/100ps
module slirq_tx_model (
   input  wire logic         clk_in,
   input  wire logic         send_in,
   input  wire logic         bad_cks_in,
   output logic      [111:0] ilas_out,
   output logic      [7:0]   cks_out,
   output logic              done_out
);
   logic [7:0] cks;
   // The frame is held after sending, as the receiver compares it in the done cycle.
   always_comb begin
      cks = 8'h00;
      for (int i = 0; i < 13; i++) begin
         ilas_out[8*i+:8] = 8'h10 + 8'(i);
         cks = cks + 8'h10 + 8'(i);
      end
      cks_out = bad_cks_in ? ~cks : cks;
      ilas_out[111:104] = cks_out;
   end
   always_ff @(posedge clk_in) begin
      done_out <= send_in;
   end
endmodule // slirq_tx_model

// >>> tb_slirq_top.sv
// Purpose: Self-checking bench for the link interrupt enable block.
// Assumes: Registered read data, one cycle after the address.
// Notes:   Inputs move 1 ns after the rising edge.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb_slirq_top;
   logic         clk_in, resetn_in, wr, send, bad, irq, done;
   logic [11:0]  addr;
   logic [7:0]   wd, rd, ev, scks;
   logic [111:0] rx, cfg;
   int           fail_count = 0;
   int           checks = 0;
   int           cyc = 0;
   slirq_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in),
      .reg_addr_in(addr), .reg_write_in(wr), .reg_wdata_in(wd),
      .reg_rdata_out(rd), .link_event_in(ev), .ilas_done_in(done),
      .ilas_rx_in(rx), .ilas_cfg_in(cfg), .ilas_sent_cks_in(scks),
      .irq_out(irq));
   slirq_tx_model u_tx (.clk_in(clk_in), .send_in(send),
      .bad_cks_in(bad), .ilas_out(rx), .cks_out(scks), .done_out(done));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // The ceiling is nearly four times the expected run length.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 600) begin
         fail_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic step();
      @(posedge clk_in);
      #1;
   endtask
   // An idle edge follows each write, so back-to-back writes never
   // lower and raise the strobe in one time step.
   task automatic wreg(input logic [11:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1'b1;
      step();
      wr = 1'b0;
      step();
   endtask
   task automatic rreg(input logic [11:0] a, input logic [7:0] e,
                       input string n);
      addr = a;
      step();
      `CHK(n, e, rd)
   endtask
   task automatic pulse(input logic [7:0] e);
      ev = e;
      step();
      ev = 8'h00;
   endtask
   task automatic frame();
      send = 1'b1;
      step();
      send = 1'b0;
      repeat (3) step();
   endtask
   initial begin
      {resetn_in, wr, send, bad, addr, wd, ev} = '0;
      cfg = '0;
      repeat (8) @(posedge clk_in);
      #1 resetn_in = 1'b1;
      repeat (3) step();
      rreg(slirq_pkg::ADDR_ENABLE_A, 8'h00, "enable a reset");
      rreg(slirq_pkg::ADDR_ENABLE_B, 8'h00, "enable b reset");
      wreg(slirq_pkg::ADDR_ENABLE_A, 8'hFF);
      rreg(slirq_pkg::ADDR_ENABLE_A, 8'hFF, "enable a rw");
      wreg(slirq_pkg::ADDR_ENABLE_B, 8'hFF);
      rreg(slirq_pkg::ADDR_ENABLE_B, 8'h01, "enable b rw");
      rreg(12'h4BC, 8'h00, "unmapped");
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         if (i == slirq_pkg::BIT_CHECKSUM) begin
            pulse(8'h04);
            step();
            rreg(slirq_pkg::ADDR_STATUS_A, 8'h00, "bit 2 ignored");
            continue;
         end
         wreg(slirq_pkg::ADDR_ENABLE_A, 8'h00);
         pulse(8'h01 << i);
         repeat (2) step();
         `CHK("irq masked", 1'b0, irq)
         rreg(slirq_pkg::ADDR_STATUS_A, 8'h01 << i, "status a");
         wreg(slirq_pkg::ADDR_ENABLE_A, 8'h01 << i);
         step();
         `CHK("irq armed", 1'b1, irq)
         wreg(slirq_pkg::ADDR_STATUS_A, 8'h01 << i);
         repeat (2) step();
         `CHK("irq cleared", 1'b0, irq)
      end
      addr = slirq_pkg::ADDR_STATUS_A;
      wd = 8'h80;
      wr = 1'b1;
      pulse(8'h80);
      wr = 1'b0;
      rreg(slirq_pkg::ADDR_STATUS_A, 8'h80, "set beats clear");
      wreg(slirq_pkg::ADDR_STATUS_A, 8'h80);
      $display("test events done");
      cfg = rx;
      wreg(slirq_pkg::ADDR_ENABLE_A, 8'h04);
      wreg(slirq_pkg::ADDR_ENABLE_B, 8'h01);
      frame();
      `CHK("irq checksum", 1'b1, irq)
      rreg(slirq_pkg::ADDR_STATUS_A, 8'h04, "checksum good");
      rreg(slirq_pkg::ADDR_STATUS_B, 8'h00, "no mismatch");
      wreg(slirq_pkg::ADDR_STATUS_A, 8'h04);
      cfg[111:104] = cfg[111:104] ^ 8'h01;
      frame();
      rreg(slirq_pkg::ADDR_STATUS_A, 8'h04, "programmed cks ignored");
      rreg(slirq_pkg::ADDR_STATUS_B, 8'h01, "cks octet mismatch");
      wreg(slirq_pkg::ADDR_STATUS_A, 8'h04);
      step();
      `CHK("irq mismatch", 1'b1, irq)
      wreg(slirq_pkg::ADDR_ENABLE_B, 8'h00);
      step();
      `CHK("irq mismatch gated", 1'b0, irq)
      wreg(slirq_pkg::ADDR_STATUS_B, 8'h01);
      wreg(slirq_pkg::ADDR_ENABLE_B, 8'h01);
      cfg = rx;
      cfg[7:0] = cfg[7:0] ^ 8'h01;
      frame();
      rreg(slirq_pkg::ADDR_STATUS_A, 8'h04, "checksum still good");
      rreg(slirq_pkg::ADDR_STATUS_B, 8'h01, "octet 0 mismatch");
      wreg(slirq_pkg::ADDR_STATUS_A, 8'h04);
      wreg(slirq_pkg::ADDR_STATUS_B, 8'h01);
      cfg = rx;
      bad = 1'b1;
      frame();
      rreg(slirq_pkg::ADDR_STATUS_A, 8'h00, "checksum bad");
      rreg(slirq_pkg::ADDR_STATUS_B, 8'h01, "rx mismatch");
      $display("test ilas done");
      summarize();
   end
endmodule // tb_slirq_top
